// file: design/mch_motion_cmd.sv
// Operation
// - velocity move ramps to signed target within +-1,200,000 steps/s
// - further velocity moves change target while running, reversal too
// - slew uses accel_rate when speeding up, decel_rate when slowing
// - halt_cmd, ESCAPE or Control-C leave constant-velocity operation
// - soft limits stay enforced in constant velocity unless disabled
// - velocity move accepted only when idle or in constant velocity
// - hard limit active for direction rejects move with hard reply
// - soft limit reached for direction rejects move with soft reply
// - pending abort rejects velocity move with that abort's reply
// - actual offset adds to actual and commanded position, any state but cam entry
// - cam begin opens one of eight tables, argument 0 to 7
// - in cam entry only point and finish allowed, else illegal
// - cam commands stored not executed until finish closes entry
// - break or memory exhaustion discards cam and returns to idle
// - cam modulo computed from stored points when entry ends
// - cam begin only servo idle; stepper gives not-allowed reply
// - timed wait, idle only, runs 1 to 2,000,000 ms then idle
// - idle wait holds later commands until controller is idle
// - input offset adds to input position, idle or constant velocity
// - creep tail persisted on persist command; bad value out of range
// - creep tail default 0 in servo mode, 10 in stepper mode
// - idle means no move, wait or cam entry running and no abort pending
`default_nettype none
module mch_motion_cmd
   import mch_pkg::*;
#(
   parameter int CYC_PER_MS = mch_pkg::CYC_PER_MS
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire mch_cmd_t cmd_in,
   input wire logic brk_in,
   output logic cmd_ready_out,
   output logic reply_valid_out,
   output mch_reply_t reply_code_out,
   input wire logic stepper_mode_in,
   input wire logic hard_lim_pos_in,
   input wire logic hard_lim_neg_in,
   input wire logic soft_reach_pos_in,
   input wire logic soft_reach_neg_in,
   input wire logic soft_bound_en_in,
   input wire mch_abort_t abort_in,
   input wire logic [31:0] accel_rate_in,
   input wire logic [31:0] decel_rate_in,
   input wire logic signed [15:0] enc_delta_in,
   input wire logic signed [15:0] in_delta_in,
   input wire logic signed [15:0] traj_delta_in,
   input wire logic [CAM_AW-1:0] cam_rd_addr_in,
   output mch_state_t op_state_out,
   output logic idle_out,
   output logic signed [31:0] target_vel_out,
   output logic signed [31:0] vel_out,
   output logic signed [31:0] act_pos_out,
   output logic signed [31:0] in_pos_out,
   output logic signed [31:0] cmd_pos_out,
   output logic [31:0] tail_steps_out,
   output logic flash_wr_out,
   output logic cam_done_out,
   output logic [2:0] cam_id_out,
   output logic signed [31:0] cam_mod_out,
   output logic [CAM_AW:0] cam_cnt_out,
   output logic signed [63:0] cam_rd_out
);
   typedef struct packed {
      mch_state_t st;
      logic signed [31:0] tgt;
      logic signed [31:0] vel;
      logic signed [31:0] act;
      logic signed [31:0] inp;
      logic signed [31:0] cpos;
      logic [31:0] tail;
      logic tail_init;
      logic wait_idle;
      logic rvld;
      mch_reply_t rcode;
      logic flash_wr;
      logic [2:0] cam_id;
      logic [CAM_AW:0] cam_cnt;
      logic signed [31:0] cam_last_x;
      logic signed [31:0] cam_mod;
      logic cam_done;
      logic [1:0] hl_m;
      logic [1:0] hl_s;
      logic signed [63:0] rd;
   } mch_st_t;

   mch_st_t q, d;
   logic signed [63:0] cam_mem [0:(1 << CAM_AW)-1];
   logic cam_we;
   logic is_idle;
   logic take;
   logic tmr_start;
   logic tmr_cancel;
   logic tick;
   logic tmr_done;
   logic tmr_busy;
   logic go_pos;
   mch_reply_t ab_reply;

   mch_ms_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_tmr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(tmr_start),
      .ms_in(cmd_in.arg_a[20:0]),
      .cancel_in(tmr_cancel),
      .tick_out(tick),
      .done_out(tmr_done),
      .busy_out(tmr_busy)
   );

   // ****************************************
   // slew one step per ms
   // ****************************************
   function automatic logic signed [31:0] slew(
      input logic signed [31:0] cur,
      input logic signed [31:0] tgt,
      input logic [31:0] acc,
      input logic [31:0] dec
   );
      logic up;
      logic signed [32:0] diff;
      logic signed [32:0] step;
      up = (tgt > cur && cur >= 0) || (tgt < cur && cur <= 0);
      diff = 33'(tgt) - 33'(cur);
      step = signed'({1'b0, up ? acc : dec});
      if (diff > step)
         slew = 32'(33'(cur) + step);
      else if (diff < -step)
         slew = 32'(33'(cur) - step);
      else
         slew = tgt;
   endfunction

   // ****************************************
   // command interpreter
   // ****************************************
   assign is_idle = (q.st == ST_IDLE) && (abort_in == AB_NONE);
   assign cmd_ready_out = !(q.wait_idle && !is_idle);
   assign take = cmd_valid_in && cmd_ready_out;
   assign go_pos = !cmd_in.arg_a[31];

   always_comb
   begin
      unique case (abort_in)
         AB_INPUT: ab_reply = RP_INPUT_ABORT;
         AB_STALL: ab_reply = RP_STALL_ABORT;
         AB_TRACK: ab_reply = RP_TRACK_ABORT;
         AB_TIMEOUT: ab_reply = RP_TIMEOUT_ABORT;
         default: ab_reply = RP_OK;
      endcase
   end

   always_comb
   begin
      d = q;
      d.rvld = 1'b0;
      d.flash_wr = 1'b0;
      d.cam_done = 1'b0;
      cam_we = 1'b0;
      tmr_start = 1'b0;
      tmr_cancel = 1'b0;
      d.hl_m = {hard_lim_pos_in, hard_lim_neg_in};
      d.hl_s = q.hl_m;
      d.rd = cam_mem[cam_rd_addr_in];
      // wrapping counters, deltas sign-extended
      d.act = q.act + 32'(enc_delta_in);
      d.inp = q.inp + 32'(in_delta_in);
      d.cpos = q.cpos + 32'(traj_delta_in);
      if (!q.tail_init)
      begin
         // mode strap taken once after reset release
         d.tail_init = 1'b1;
         d.tail = stepper_mode_in ? TAIL_STEP : TAIL_SERVO;
      end
      if (is_idle)
         d.wait_idle = 1'b0;
      if (tick && (q.st == ST_VEL || q.st == ST_STOP))
         d.vel = slew(q.vel, q.tgt, accel_rate_in, decel_rate_in);
      if (q.st == ST_STOP && q.vel == 32'sh0)
         d.st = ST_IDLE;
      if (q.st == ST_VEL && soft_bound_en_in &&
          ((q.vel > 0 && soft_reach_pos_in) ||
           (q.vel < 0 && soft_reach_neg_in)))
      begin
         d.st = ST_STOP;
         d.tgt = 32'sh0;
      end
      if (q.st == ST_VEL && abort_in != AB_NONE)
      begin
         d.st = ST_STOP;
         d.tgt = 32'sh0;
      end
      if (tmr_done && q.st == ST_DELAY)
         d.st = ST_IDLE;
      if (brk_in)
      begin
         unique case (q.st)
            ST_VEL:
            begin
               d.st = ST_STOP;
               d.tgt = 32'sh0;
            end
            ST_DELAY:
            begin
               d.st = ST_IDLE;
               tmr_cancel = 1'b1;
            end
            ST_CAM:
            begin
               d.st = ST_IDLE;
               d.rvld = 1'b1;
               d.rcode = RP_CAM_DISCARD;
            end
            default:
            begin
            end
         endcase
      end
      else if (take)
      begin
         d.rvld = 1'b1;
         d.rcode = RP_OK;
         if (q.st == ST_CAM)
         begin
            unique case (cmd_in.code)
               CMD_CAM_PT:
                  if (q.cam_cnt == CAM_DEPTH)
                  begin
                     d.st = ST_IDLE;
                     d.rcode = RP_CAM_DISCARD;
                  end
                  else
                  begin
                     cam_we = 1'b1;
                     d.cam_cnt = q.cam_cnt + 7'h1;
                     d.cam_last_x = cmd_in.arg_a;
                  end
               CMD_CAM_FIN:
               begin
                  d.st = ST_IDLE;
                  d.cam_mod = q.cam_last_x;
                  d.cam_done = 1'b1;
               end
               default:
                  d.rcode = RP_ILLEGAL_CAM;
            endcase
         end
         else
         begin
            unique case (cmd_in.code)
               CMD_VEL:
                  if (!(is_idle || q.st == ST_VEL) &&
                      abort_in == AB_NONE)
                     d.rcode = RP_NOT_IDLE;
                  else if (cmd_in.arg_a > VEL_MAX ||
                           cmd_in.arg_a < -VEL_MAX)
                     d.rcode = RP_OUT_OF_RANGE;
                  else if (abort_in != AB_NONE)
                     d.rcode = ab_reply;
                  else if (go_pos ? q.hl_s[1] : q.hl_s[0])
                     d.rcode = RP_HARD_LIMIT;
                  else if (go_pos ? soft_reach_pos_in : soft_reach_neg_in)
                     d.rcode = RP_SOFT_LIMIT;
                  else
                  begin
                     d.st = ST_VEL;
                     d.tgt = cmd_in.arg_a;
                  end
               CMD_ACT_OFS:
               begin
                  d.act = d.act + cmd_in.arg_a;
                  d.cpos = d.cpos + cmd_in.arg_a;
               end
               CMD_IN_OFS:
                  if (is_idle || q.st == ST_VEL)
                     d.inp = d.inp + cmd_in.arg_a;
                  else
                     d.rcode = RP_NOT_IDLE;
               CMD_CAM_BEGIN:
                  if (stepper_mode_in)
                     d.rcode = RP_NOT_STEPPER;
                  else if (!is_idle)
                     d.rcode = RP_NOT_IDLE;
                  else if (cmd_in.arg_a < 0 || cmd_in.arg_a > 32'sh7)
                     d.rcode = RP_OUT_OF_RANGE;
                  else
                  begin
                     d.st = ST_CAM;
                     d.rcode = RP_CAM_START;
                     d.cam_id = cmd_in.arg_a[2:0];
                     d.cam_cnt = '0;
                     d.cam_last_x = 32'sh0;
                  end
               CMD_WAIT:
                  if (!is_idle)
                     d.rcode = RP_NOT_IDLE;
                  else if (cmd_in.arg_a < signed'({11'h0, DLY_MIN}) ||
                           cmd_in.arg_a > signed'({11'h0, DLY_MAX}))
                     d.rcode = RP_OUT_OF_RANGE;
                  else
                  begin
                     d.st = ST_DELAY;
                     tmr_start = 1'b1;
                  end
               CMD_HALT:
                  if (q.st == ST_VEL)
                  begin
                     d.st = ST_STOP;
                     d.tgt = 32'sh0;
                  end
               CMD_IDLE_WAIT:
                  d.wait_idle = !is_idle;
               CMD_SET_TAIL:
                  if (!is_idle)
                     d.rcode = RP_NOT_IDLE;
                  else if (cmd_in.arg_a < 0)
                     d.rcode = RP_OUT_OF_RANGE;
                  else
                     d.tail = cmd_in.arg_a;
               CMD_PERSIST:
                  d.flash_wr = 1'b1;
               default:
               begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q <= '0;
         q.st <= ST_IDLE;
         q.act <= POS_RST;
         q.inp <= POS_RST;
         q.cpos <= POS_RST;
         q.tail <= TAIL_SERVO;
         q.rcode <= RP_OK;
      end
      else
         q <= d;
   end

   // volatile point store, no reset needed
   always_ff @(posedge clk_in)
   begin
      if (cam_we)
         cam_mem[q.cam_cnt[CAM_AW-1:0]] <= {cmd_in.arg_a, cmd_in.arg_b};
   end

   assign reply_valid_out = q.rvld;
   assign reply_code_out = q.rcode;
   assign op_state_out = q.st;
   assign idle_out = is_idle;
   assign target_vel_out = q.tgt;
   assign vel_out = q.vel;
   assign act_pos_out = q.act;
   assign in_pos_out = q.inp;
   assign cmd_pos_out = q.cpos;
   assign tail_steps_out = q.tail;
   assign flash_wr_out = q.flash_wr;
   assign cam_done_out = q.cam_done;
   assign cam_id_out = q.cam_id;
   assign cam_mod_out = q.cam_mod;
   assign cam_cnt_out = q.cam_cnt;
   assign cam_rd_out = q.rd;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_vel_bound: assert property (q.tgt <= VEL_MAX && q.tgt >= -VEL_MAX)
      else $error("target speed out of bounds");
   a_hard_reject: assert property (take && !brk_in && q.st != ST_CAM &&
      cmd_in.code == CMD_VEL && abort_in == AB_NONE && go_pos &&
      q.hl_s[1] && q.st == ST_IDLE && cmd_in.arg_a <= VEL_MAX
      |=> q.rcode == RP_HARD_LIMIT && q.st == ST_IDLE)
      else $error("hard limit move not rejected");
   a_abort_reject: assert property (take && !brk_in && q.st == ST_IDLE &&
      cmd_in.code == CMD_VEL && abort_in == AB_STALL &&
      cmd_in.arg_a <= VEL_MAX && cmd_in.arg_a >= -VEL_MAX
      |=> q.rcode == RP_STALL_ABORT && q.rvld)
      else $error("abort pending move not rejected");
   a_stepper_cam: assert property (take && !brk_in && q.st != ST_CAM &&
      cmd_in.code == CMD_CAM_BEGIN && stepper_mode_in
      |=> q.rcode == RP_NOT_STEPPER && q.st != ST_CAM)
      else $error("cam begin allowed in stepper mode");
   a_act_offset: assert property (take && !brk_in && q.st != ST_CAM &&
      cmd_in.code == CMD_ACT_OFS |=> q.act == $past(q.act) +
      $past(cmd_in.arg_a) + 32'($past(enc_delta_in)) &&
      q.cpos == $past(q.cpos) + $past(cmd_in.arg_a) +
      32'($past(traj_delta_in)))
      else $error("actual offset not applied");
   a_cam_illegal: assert property (take && !brk_in && q.st == ST_CAM &&
      cmd_in.code == CMD_VEL |=> q.rcode == RP_ILLEGAL_CAM &&
      q.st == ST_CAM && q.tgt == $past(q.tgt))
      else $error("command executed during cam entry");
   a_cam_break: assert property (brk_in && q.st == ST_CAM
      |=> q.st == ST_IDLE && !q.cam_done)
      else $error("cam not discarded on break");
   a_delay_end: assert property (q.st == ST_DELAY && tmr_done && !brk_in
      |=> q.st == ST_IDLE)
      else $error("delay expiry did not return to idle");
   a_ready_hold: assert property (q.wait_idle && !is_idle
      |=> q.wait_idle && !q.rvld)
      else $error("commands not held during idle wait");
   a_tail_range: assert property (take && !brk_in && q.st == ST_IDLE &&
      abort_in == AB_NONE && cmd_in.code == CMD_SET_TAIL &&
      cmd_in.arg_a < 0 |=> q.rcode == RP_OUT_OF_RANGE &&
      $stable(q.tail))
      else $error("negative creep tail accepted");

   c_vel_start: cover property (q.st == ST_IDLE ##1 q.st == ST_VEL);
   c_vel_reverse: cover property (q.st == ST_VEL && q.vel > 0
      ##[1:300] q.vel < 0);
   c_cam_done: cover property (q.cam_done && q.cam_cnt > 7'h1);
   c_delay_end: cover property (q.st == ST_DELAY ##1 q.st == ST_IDLE);
endmodule
`default_nettype wire

// file: design/mch_ms_timer.sv
`default_nettype none
module mch_ms_timer
   import mch_pkg::*;
#(
   parameter int CYC_PER_MS = mch_pkg::CYC_PER_MS
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic [20:0] ms_in,
   input wire logic cancel_in,
   output logic tick_out,
   output logic done_out,
   output logic busy_out
);
   typedef struct packed {
      logic [31:0] pre;
      logic [20:0] left;
      logic busy;
      logic tick;
      logic done;
   } mch_tmr_t;
   mch_tmr_t q, d;
   logic wrap;

   // ****************************************
   // free-running ms tick and countdown
   // ****************************************
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      wrap = (q.pre == 32'(CYC_PER_MS - 1));
      d.pre = wrap ? 32'h0 : q.pre + 32'h1;
      d.tick = wrap;
      if (start_in)
      begin
         // restart prescaler so the first ms is a whole one
         d.pre = 32'h0;
         d.left = ms_in;
         d.busy = 1'b1;
      end
      else if (cancel_in)
         d.busy = 1'b0;
      else if (q.busy && wrap)
      begin
         d.left = q.left - 21'h1;
         if (q.left == 21'h1)
         begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         q <= '0;
      else
         q <= d;
   end

   assign tick_out = q.tick;
   assign done_out = q.done;
   assign busy_out = q.busy;
endmodule
`default_nettype wire

// file: design/mch_pkg.sv
`default_nettype none
package mch_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam logic [20:0] DLY_MIN = 21'h000001;
   localparam logic [20:0] DLY_MAX = 21'h1E8480;
   // ****************************************
   // limits and reset values
   // ****************************************
   localparam logic signed [31:0] VEL_MAX = 32'sh0012_4F80;
   localparam logic [31:0] TAIL_SERVO = 32'h0000_0000;
   localparam logic [31:0] TAIL_STEP = 32'h0000_000A;
   localparam logic [31:0] POS_RST = 32'h0000_0000;
   localparam int CAM_AW = 6;
   localparam logic [CAM_AW:0] CAM_DEPTH = 7'h40;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      CMD_VEL, CMD_ACT_OFS, CMD_CAM_BEGIN, CMD_WAIT, CMD_IN_OFS,
      CMD_CAM_PT, CMD_CAM_FIN, CMD_HALT, CMD_IDLE_WAIT, CMD_SET_TAIL,
      CMD_PERSIST, CMD_OTHER
   } mch_code_t;
   typedef enum logic [3:0] {
      RP_OK, RP_CAM_START, RP_HARD_LIMIT, RP_SOFT_LIMIT, RP_INPUT_ABORT,
      RP_STALL_ABORT, RP_TRACK_ABORT, RP_TIMEOUT_ABORT, RP_NOT_STEPPER,
      RP_ILLEGAL_CAM, RP_OUT_OF_RANGE, RP_NOT_IDLE, RP_CAM_DISCARD
   } mch_reply_t;
   typedef enum logic [2:0] {
      AB_NONE, AB_INPUT, AB_STALL, AB_TRACK, AB_TIMEOUT
   } mch_abort_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_VEL, ST_STOP, ST_DELAY, ST_CAM
   } mch_state_t;
   typedef struct packed {
      mch_code_t code;
      logic signed [31:0] arg_a;
      logic signed [31:0] arg_b;
   } mch_cmd_t;
   typedef struct packed {
      logic hard_pos;
      logic hard_neg;
      logic soft_pos;
      logic soft_neg;
   } mch_lim_t;
endpackage
`default_nettype wire

// file: tb/mch_host.sv
`default_nettype none
module mch_host
   import mch_pkg::*;
(
   input wire logic clk_in,
   input wire logic ready_in,
   input wire logic rvalid_in,
   input wire mch_reply_t rcode_in,
   output logic valid_out,
   output mch_cmd_t cmd_out,
   output logic brk_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // host side of the command port
   // ****************************************
   initial
   begin
      valid_out = 1'b0;
      cmd_out = '0;
      brk_out = 1'b0;
   end
   // strobe held until the take edge; a missing reply reads as unknown
   task automatic send(input mch_code_t c, input logic [31:0] a,
      input logic [31:0] b, output mch_reply_t r);
      bit tk;
      @(negedge clk_in);
      valid_out = 1'b1;
      cmd_out = '{c, a, b};
      tk = 0;
      while (!tk)
      begin
         @(posedge clk_in);
         tk = (ready_in === 1'b1);
      end
      @(negedge clk_in);
      valid_out = 1'b0;
      r = (rvalid_in === 1'b1) ? rcode_in : mch_reply_t'(4'hX);
   endtask
   task automatic brk();
      @(negedge clk_in);
      brk_out = 1'b1;
      @(negedge clk_in);
      brk_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: tb/mch_motion_cmd_tb.sv
`default_nettype none
module mch_motion_cmd_tb
   import mch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // bench
   // ****************************************
   localparam int CPM = 10; // short ms tick keeps waits brief
   localparam int LIMIT = 6000;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic v, bk, rdy, rv, stp, hp, hn, sp, sn, fw, cd, idl, sbe;
   mch_cmd_t cmd;
   mch_reply_t rc, r;
   mch_abort_t ab;
   mch_state_t st;
   logic [31:0] acc, dec, tail;
   logic [5:0] addr;
   logic signed [31:0] tv, vel, ap, ip, cp, cmod;
   logic [6:0] ccnt;
   logic [2:0] cid;
   logic signed [63:0] crd;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   always #10 clk_in = ~clk_in;
   mch_host host_u (.clk_in(clk_in), .ready_in(rdy), .rvalid_in(rv),
      .rcode_in(rc), .valid_out(v), .cmd_out(cmd), .brk_out(bk));
   mch_motion_cmd #(.CYC_PER_MS(CPM)) dut_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(v),
      .cmd_in(cmd), .brk_in(bk), .cmd_ready_out(rdy),
      .reply_valid_out(rv), .reply_code_out(rc), .stepper_mode_in(stp),
      .hard_lim_pos_in(hp), .hard_lim_neg_in(hn),
      .soft_reach_pos_in(sp), .soft_reach_neg_in(sn),
      .soft_bound_en_in(sbe), .abort_in(ab), .accel_rate_in(acc),
      .decel_rate_in(dec), .enc_delta_in(16'sh0000),
      .in_delta_in(16'sh0000), .traj_delta_in(16'sh0000),
      .cam_rd_addr_in(addr), .op_state_out(st), .idle_out(idl),
      .target_vel_out(tv), .vel_out(vel), .act_pos_out(ap),
      .in_pos_out(ip), .cmd_pos_out(cp), .tail_steps_out(tail),
      .flash_wr_out(fw), .cam_done_out(cd), .cam_id_out(cid),
      .cam_mod_out(cmod), .cam_cnt_out(ccnt), .cam_rd_out(crd));
   task automatic check(input string n, input logic [31:0] s, e);
      check_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("FAIL %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         mismatches++;
         summarize();
      end
   end
   task automatic wait_idle();
      int n;
      n = 0;
      while (idl !== 1'b1 && n < 200)
      begin
         @(negedge clk_in);
         n++;
      end
      check("idle", idl, 1'b1);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_ofs();
      host_u.send(CMD_ACT_OFS, 32'h7FFFFFFF, 32'h0, r);
      check("act", ap, 32'h7FFFFFFF);
      host_u.send(CMD_ACT_OFS, 32'h1, 32'h0, r);
      check("act wrap", ap, 32'h80000000);
      check("cmd wrap", cp, 32'h80000000);
      host_u.send(CMD_IN_OFS, 32'hFFFFFFFB, 32'h0, r);
      check("in", ip, 32'hFFFFFFFB);
      $display("test offsets done");
   endtask
   task automatic t_vel();
      host_u.send(CMD_VEL, 32'h7D0, 32'h0, r);
      check("vel ok", r, RP_OK);
      check("vel st", st, ST_VEL);
      check("vel tgt", tv, 32'h7D0);
      repeat (3 * CPM) @(negedge clk_in);
      check("ramp", vel > 0 && vel <= 32'sh190, 1'b1);
      host_u.send(CMD_VEL, 32'hFFFFF448, 32'h0, r);
      check("reverse", tv, 32'hFFFFF448);
      host_u.send(CMD_VEL, 32'h124F80, 32'h0, r);
      check("max", tv, 32'h124F80);
      host_u.send(CMD_VEL, 32'h124F81, 32'h0, r);
      check("over", r, RP_OUT_OF_RANGE);
      host_u.send(CMD_WAIT, 32'h1, 32'h0, r);
      check("wait busy", r, RP_NOT_IDLE);
      host_u.send(CMD_IN_OFS, 32'h1, 32'h0, r);
      check("in ofs", r, RP_OK);
      dec = 32'h00FFFFFF;
      host_u.send(CMD_HALT, 32'h0, 32'h0, r);
      repeat (2) @(negedge clk_in);
      check("halt", st == ST_VEL, 1'b0);
      wait_idle();
      host_u.send(CMD_VEL, 32'h7D0, 32'h0, r);
      host_u.brk();
      @(negedge clk_in);
      check("break", st == ST_VEL, 1'b0);
      wait_idle();
      $display("test velocity done");
   endtask
   task automatic t_rej();
      mch_reply_t ex[4] = '{RP_INPUT_ABORT, RP_STALL_ABORT,
         RP_TRACK_ABORT, RP_TIMEOUT_ABORT};
      hp = 1'b1;
      repeat (3) @(negedge clk_in);
      host_u.send(CMD_VEL, 32'h5, 32'h0, r);
      check("hard", r, RP_HARD_LIMIT);
      hp = 1'b0;
      sp = 1'b1;
      repeat (3) @(negedge clk_in);
      host_u.send(CMD_VEL, 32'h5, 32'h0, r);
      check("soft", r, RP_SOFT_LIMIT);
      sp = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         ab = mch_abort_t'(i + 1);
         @(negedge clk_in);
         check("abort idle", idl, 1'b0);
         host_u.send(CMD_VEL, 32'h5, 32'h0, r);
         check("abort", r, ex[i]);
      end
      ab = AB_NONE;
      $display("test rejects done");
   endtask
   // limit hit mid-move: enabled bound stops, disabled bound runs on
   task automatic t_soft();
      for (int i = 0; i < 2; i++)
      begin
         sbe = (i == 0);
         host_u.send(CMD_VEL, 32'h7D0, 32'h0, r);
         repeat (2 * CPM) @(negedge clk_in);
         sp = 1'b1;
         repeat (2) @(negedge clk_in);
         check("soft cv", st == ST_VEL, i);
         sp = 1'b0;
         host_u.send(CMD_HALT, 32'h0, 32'h0, r);
         wait_idle();
      end
      sbe = 1'b1;
      $display("test soft limit done");
   endtask
   task automatic t_delay();
      int t0;
      host_u.send(CMD_WAIT, 32'h0, 32'h0, r);
      check("wait zero", r, RP_OUT_OF_RANGE);
      t0 = cyc;
      host_u.send(CMD_WAIT, 32'h2, 32'h0, r);
      check("delay", st, ST_DELAY);
      host_u.send(CMD_IDLE_WAIT, 32'h0, 32'h0, r);
      check("held", rdy, 1'b0);
      host_u.send(CMD_IN_OFS, 32'h3, 32'h0, r);
      check("late ok", r, RP_OK);
      check("span", cyc - t0 >= CPM && cyc - t0 <= 2 * CPM + 6, 1);
      $display("test delay done");
   endtask
   task automatic t_cam();
      stp = 1'b1;
      host_u.send(CMD_CAM_BEGIN, 32'h0, 32'h0, r);
      check("stepper", r, RP_NOT_STEPPER);
      stp = 1'b0;
      host_u.send(CMD_CAM_BEGIN, 32'h8, 32'h0, r);
      check("cam8", r, RP_OUT_OF_RANGE);
      host_u.send(CMD_CAM_BEGIN, 32'h3, 32'h0, r);
      check("begin", r, RP_CAM_START);
      host_u.send(CMD_CAM_PT, 32'hC8, 32'h1F4, r);
      host_u.send(CMD_CAM_PT, 32'h2EE, 32'h0, r);
      host_u.send(CMD_VEL, 32'h5, 32'h0, r);
      check("illegal", r, RP_ILLEGAL_CAM);
      check("not run", st, ST_CAM);
      host_u.send(CMD_CAM_FIN, 32'h0, 32'h0, r);
      check("done", cd, 1'b1);
      check("modulo", cmod, 32'h2EE);
      check("count", ccnt, 7'h02);
      check("id", cid, 3'h3);
      addr = 6'h00;
      repeat (2) @(negedge clk_in);
      check("x0", crd[63:32], 32'hC8);
      check("y0", crd[31:0], 32'h1F4);
      host_u.send(CMD_CAM_BEGIN, 32'h1, 32'h0, r);
      host_u.send(CMD_CAM_PT, 32'h10, 32'h10, r);
      host_u.brk();
      @(negedge clk_in);
      check("discard", rc, RP_CAM_DISCARD);
      check("back idle", st, ST_IDLE);
      $display("test cam done");
   endtask
   task automatic t_tail();
      host_u.send(CMD_SET_TAIL, 32'h32, 32'h0, r);
      check("tail", tail, 32'h32);
      host_u.send(CMD_SET_TAIL, 32'hFFFFFFFF, 32'h0, r);
      check("tail bad", r, RP_OUT_OF_RANGE);
      check("tail kept", tail, 32'h32);
      host_u.send(CMD_PERSIST, 32'h0, 32'h0, r);
      check("flash", fw, 1'b1);
      $display("test tail done");
   endtask
   initial
   begin
      {stp, hp, hn, sp, sn, sbe} = 6'h01;
      ab = AB_NONE;
      acc = 32'h64;
      dec = 32'h64;
      addr = '0;
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clk_in);
      check("servo tail", tail, 32'h0);
      check("rst idle", idl, 1'b1);
      t_ofs();
      t_vel();
      t_rej();
      t_soft();
      t_delay();
      t_cam();
      t_tail();
      rst_n_in = 1'b0;
      stp = 1'b1;
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clk_in);
      check("step tail", tail, 32'hA);
      check("pos rst", ap, 32'h0);
      $display("test stepper reset done");
      summarize();
   end
endmodule
`default_nettype wire
